// ### pisw_pkg.sv
// package for the peripheral interrupt flag and sleep/wake block
// assumes an 8-bit register port driven by the core on the system clock
package pisw_pkg;

  // ------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CORE_IRQ_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_PERIPH_IRQ_ENABLE_1 = 4'h1;
  localparam logic [3:0] ADDR_PERIPH_IRQ_ENABLE_2 = 4'h2;
  localparam logic [3:0] ADDR_PERIPH_IRQ_REQUEST_1 = 4'h3;
  localparam logic [3:0] ADDR_PERIPH_IRQ_REQUEST_2 = 4'h4;
  localparam logic [3:0] ADDR_REGULATOR_CONTROL = 4'h5;
  localparam logic [3:0] ADDR_POWER_STATUS = 4'h6;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int GLOBAL_IRQ_EN_BIT = 7;
  localparam int PERIPHERAL_GROUP_IRQ_EN_BIT = 6;
  localparam int TIMER0_IRQ_EN_BIT = 5;
  localparam int EXT_IRQ_EN_BIT = 4;
  localparam int CHANGE_IRQ_EN_BIT = 3;
  localparam int TIMER0_PENDING_BIT = 2;
  localparam int EXT_PENDING_BIT = 1;
  localparam int CHANGE_PENDING_BIT = 0;
  localparam int SERIAL_RX_PENDING_BIT = 5;
  localparam int SERIAL_TX_PENDING_BIT = 4;
  localparam int REGULATOR_LOWPOWER_SELECT_BIT = 1;
  localparam int TIMEOUT_STATUS_BIT = 1;
  localparam int POWERDOWN_STATUS_BIT = 0;

  // implemented-bit masks
  localparam logic [7:0] REQUEST_2_MASK = 8'h89; // bits 7, 3, 0
  localparam logic [7:0] REQUEST_1_SW_MASK = 8'hcf; // rx/tx not writable
  localparam logic [7:0] CORE_SW_MASK = 8'hfe; // change flag read-only
  localparam logic [7:0] REGULATOR_MASK = 8'h03;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CORE_IRQ_CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIPH_IRQ_RST = 8'h00;
  localparam logic [7:0] REGULATOR_CONTROL_RST = 8'h01; // reserved bit reads one
  localparam logic [14:0] IRQ_VECTOR_ADDR = 15'h0004;

  // power-down controller states
  typedef enum logic [1:0] {
    PISW_RUN = 2'b00,
    PISW_SLEEP = 2'b01,
    PISW_WAKE = 2'b10
  } pisw_state_t;

endpackage

// ### pisw_core.sv
// peripheral interrupt flags, enables and the power-down controller
// assumes event inputs are one-cycle pulses on clk_i, except the serial rx/tx,
// change summary and master-clear pin which are levels
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

module pisw_core (
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  // peripheral event pulses and levels
  input wire logic [7:0] request_1_event_i,
  input wire logic [7:0] request_2_event_i,
  input wire logic serial_rx_level_i,
  input wire logic serial_tx_level_i,
  input wire logic timer0_event_i,
  input wire logic ext_event_i,
  input wire logic change_any_i,
  // core side
  input wire logic sleep_exec_i,
  input wire logic irq_taken_i,
  input wire logic prefetch_done_i,
  input wire logic watchdog_timeout_i,
  input wire logic watchdog_sleep_enable_i,
  input wire logic master_clear_input_i,
  input wire logic brownout_reset_i,
  input wire logic poweron_reset_i,
  input wire logic converter_dedicated_osc_sel_i,
  input wire logic [1:0] timer_a_clock_sel_i,
  output logic sleep_nop_o,
  output logic cpu_clock_enable_o,
  output logic watchdog_clear_o,
  output logic watchdog_run_o,
  output logic low_freq_internal_osc_enable_o,
  output logic timer_a_run_o,
  output logic converter_run_o,
  output logic port_hold_o,
  output logic regulator_lowpower_o,
  output logic device_reset_o,
  output logic irq_request_o,
  output logic [14:0] irq_vector_o,
  output logic wake_request_o,
  output logic timeout_status_o,
  output logic powerdown_status_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] core_ctl;
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] req1;
    logic [7:0] req2;
    logic [7:0] regctl;
    logic timeout_st;
    logic powerdown_st;
    pisw_pkg::pisw_state_t mode;
    logic [7:0] rdata;
    logic wdt_clear;
    logic sleep_nop;
    logic master_clear_input_s1;
    logic master_clear_input_s2;
  } pisw_regs_t;

  pisw_regs_t st_reg;
  pisw_regs_t st_next;
  logic [7:0] req1_live;
  logic core_wake;
  logic periph_wake;
  logic wake_any;
  logic wdt_wake;
  logic hard_reset;

  // sticky flag update: set wins over a software clear
  function automatic logic [7:0] pisw_flag_upd(input logic [7:0] cur, input logic [7:0] ev,
                                               input logic wr, input logic [7:0] wd,
                                               input logic [7:0] msk);
    logic [7:0] v;
    v = cur;
    if (wr) begin
      v = (cur & ~msk) | (wd & msk);
    end
    pisw_flag_upd = v | ev;
  endfunction

  // ------------------------------------------------------------
  // wake and interrupt detection
  // ------------------------------------------------------------
  // rx/tx flags follow their source levels
  always_comb begin
    req1_live = st_reg.req1;
    req1_live[pisw_pkg::SERIAL_RX_PENDING_BIT] = serial_rx_level_i;
    req1_live[pisw_pkg::SERIAL_TX_PENDING_BIT] = serial_tx_level_i;
  end

  // peripheral group gated by its own enable
  assign periph_wake = st_reg.core_ctl[pisw_pkg::PERIPHERAL_GROUP_IRQ_EN_BIT]
                       & (|(req1_live & st_reg.en1) | |(st_reg.req2 & st_reg.en2));
  assign core_wake = (st_reg.core_ctl[pisw_pkg::TIMER0_IRQ_EN_BIT]
                      & st_reg.core_ctl[pisw_pkg::TIMER0_PENDING_BIT])
                   | (st_reg.core_ctl[pisw_pkg::EXT_IRQ_EN_BIT]
                      & st_reg.core_ctl[pisw_pkg::EXT_PENDING_BIT])
                   | (st_reg.core_ctl[pisw_pkg::CHANGE_IRQ_EN_BIT] & change_any_i);
  assign wake_any = periph_wake | core_wake;
  assign wdt_wake = watchdog_timeout_i & (st_reg.mode == pisw_pkg::PISW_SLEEP);
  assign hard_reset = st_reg.master_clear_input_s2 | brownout_reset_i | poweron_reset_i;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.wdt_clear = 1'b0;
    st_next.sleep_nop = 1'b0;
    st_next.rdata = 8'h00;
    // pin synchroniser for master clear
    st_next.master_clear_input_s1 = master_clear_input_i;
    st_next.master_clear_input_s2 = st_reg.master_clear_input_s1;

    // register writes with hardware set priority
    st_next.core_ctl = pisw_flag_upd(st_reg.core_ctl,
                                     {5'h00, timer0_event_i, ext_event_i, 1'b0},
                                     reg_write_i && reg_addr_i == pisw_pkg::ADDR_CORE_IRQ_CONTROL,
                                     reg_wdata_i, pisw_pkg::CORE_SW_MASK);
    st_next.core_ctl[pisw_pkg::CHANGE_PENDING_BIT] = change_any_i;
    if (reg_write_i && reg_addr_i == pisw_pkg::ADDR_PERIPH_IRQ_ENABLE_1) begin
      st_next.en1 = reg_wdata_i;
    end
    if (reg_write_i && reg_addr_i == pisw_pkg::ADDR_PERIPH_IRQ_ENABLE_2) begin
      st_next.en2 = reg_wdata_i & pisw_pkg::REQUEST_2_MASK;
    end
    st_next.req1 = pisw_flag_upd(st_reg.req1, request_1_event_i & pisw_pkg::REQUEST_1_SW_MASK,
                                 reg_write_i && reg_addr_i == pisw_pkg::ADDR_PERIPH_IRQ_REQUEST_1,
                                 reg_wdata_i, pisw_pkg::REQUEST_1_SW_MASK);
    st_next.req2 = pisw_flag_upd(st_reg.req2, request_2_event_i & pisw_pkg::REQUEST_2_MASK,
                                 reg_write_i && reg_addr_i == pisw_pkg::ADDR_PERIPH_IRQ_REQUEST_2,
                                 reg_wdata_i, pisw_pkg::REQUEST_2_MASK);
    if (reg_write_i && reg_addr_i == pisw_pkg::ADDR_REGULATOR_CONTROL) begin
      st_next.regctl = (reg_wdata_i & pisw_pkg::REGULATOR_MASK) | 8'h01;
    end

    // register reads, data one cycle later
    if (reg_read_i) begin
      unique case (reg_addr_i)
        pisw_pkg::ADDR_CORE_IRQ_CONTROL: st_next.rdata = st_reg.core_ctl;
        pisw_pkg::ADDR_PERIPH_IRQ_ENABLE_1: st_next.rdata = st_reg.en1;
        pisw_pkg::ADDR_PERIPH_IRQ_ENABLE_2: st_next.rdata = st_reg.en2;
        pisw_pkg::ADDR_PERIPH_IRQ_REQUEST_1: st_next.rdata = req1_live;
        pisw_pkg::ADDR_PERIPH_IRQ_REQUEST_2: st_next.rdata = st_reg.req2;
        pisw_pkg::ADDR_REGULATOR_CONTROL: st_next.rdata = st_reg.regctl;
        pisw_pkg::ADDR_POWER_STATUS: st_next.rdata = {6'h00, st_reg.timeout_st,
                                                      st_reg.powerdown_st};
        default: st_next.rdata = 8'h00;
      endcase
    end

    // power-down controller
    unique case (st_reg.mode)
      pisw_pkg::PISW_RUN: begin
        if (sleep_exec_i) begin
          if (wake_any && !st_reg.core_ctl[pisw_pkg::GLOBAL_IRQ_EN_BIT]) begin
            st_next.sleep_nop = 1'b1;
          end else begin
            st_next.powerdown_st = 1'b0;
            st_next.timeout_st = 1'b1;
            st_next.wdt_clear = 1'b1;
            st_next.mode = pisw_pkg::PISW_SLEEP;
          end
        end
      end
      pisw_pkg::PISW_SLEEP: begin
        if (wake_any || wdt_wake) begin
          st_next.wdt_clear = 1'b1;
          st_next.mode = pisw_pkg::PISW_WAKE;
          if (wdt_wake) begin
            st_next.timeout_st = 1'b0;
          end
        end
      end
      pisw_pkg::PISW_WAKE: begin
        if (prefetch_done_i) begin
          st_next.mode = pisw_pkg::PISW_RUN;
        end
      end
      default: st_next.mode = pisw_pkg::PISW_RUN;
    endcase

    // interrupt entry clears global enable
    if (irq_taken_i) begin
      st_next.core_ctl[pisw_pkg::GLOBAL_IRQ_EN_BIT] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i || hard_reset) begin
      st_reg <= '0;
      st_reg.core_ctl <= pisw_pkg::CORE_IRQ_CONTROL_RST;
      st_reg.en2 <= pisw_pkg::PERIPH_IRQ_RST;
      st_reg.regctl <= pisw_pkg::REGULATOR_CONTROL_RST;
      st_reg.powerdown_st <= 1'b1;
      st_reg.timeout_st <= 1'b1;
      st_reg.mode <= pisw_pkg::PISW_RUN;
      st_reg.master_clear_input_s1 <= st_next.master_clear_input_s1 & nrst_i;
      st_reg.master_clear_input_s2 <= st_next.master_clear_input_s2 & nrst_i; // keeps a held pin in reset
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata_o = st_reg.rdata;
  assign sleep_nop_o = st_reg.sleep_nop;
  assign cpu_clock_enable_o = (st_reg.mode != pisw_pkg::PISW_SLEEP);
  assign watchdog_clear_o = st_reg.wdt_clear;
  assign watchdog_run_o = (st_reg.mode != pisw_pkg::PISW_SLEEP) | watchdog_sleep_enable_i;
  assign low_freq_internal_osc_enable_o = 1'b1;
  assign timer_a_run_o = (st_reg.mode != pisw_pkg::PISW_SLEEP)
                         | (timer_a_clock_sel_i != 2'h0);
  assign converter_run_o = (st_reg.mode != pisw_pkg::PISW_SLEEP)
                           | converter_dedicated_osc_sel_i;
  assign port_hold_o = (st_reg.mode == pisw_pkg::PISW_SLEEP);
  assign regulator_lowpower_o = (st_reg.mode == pisw_pkg::PISW_SLEEP)
                                & st_reg.regctl[pisw_pkg::REGULATOR_LOWPOWER_SELECT_BIT];
  assign device_reset_o = hard_reset;
  // no vectoring until the prefetched instruction has run
  assign irq_request_o = wake_any & st_reg.core_ctl[pisw_pkg::GLOBAL_IRQ_EN_BIT]
                         & (st_reg.mode == pisw_pkg::PISW_RUN);
  assign irq_vector_o = pisw_pkg::IRQ_VECTOR_ADDR;
  assign wake_request_o = wake_any;
  assign timeout_status_o = st_reg.timeout_st;
  assign powerdown_status_o = st_reg.powerdown_st;

endmodule

// ### pisw_core_props.sv
// checker: timing relations at the ports of the flag and sleep/wake block
// assumes it is bound to pisw_core and runs on the single system clock
`timescale 1ns/1ps
module pisw_core_props (
  input wire logic clk_i, nrst_i, reg_read_i, sleep_exec_i, watchdog_timeout_i,
  input wire logic brownout_reset_i, sleep_nop_o, cpu_clock_enable_o, watchdog_clear_o,
  input wire logic device_reset_o, irq_request_o, wake_request_o,
  input wire logic timeout_status_o, powerdown_status_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [14:0] irq_vector_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_en2_zero; reg_read_i && reg_addr_i == 4'h2 |=> (reg_rdata_o & 8'h76) == 8'h00; endproperty
  a_en2_zero: assert property (p_en2_zero) else $error("enable 2 stray bit");
  property p_req2_zero; reg_read_i && reg_addr_i == 4'h4 |=> (reg_rdata_o & 8'h76) == 8'h00; endproperty
  a_req2_zero: assert property (p_req2_zero) else $error("request 2 stray bit");
  property p_enter;
    sleep_exec_i && cpu_clock_enable_o && !wake_request_o && !device_reset_o
      |=> !cpu_clock_enable_o && watchdog_clear_o && timeout_status_o && !powerdown_status_o;
  endproperty
  a_enter: assert property (p_enter) else $error("sleep entry wrong");
  property p_nop;
    sleep_exec_i && wake_request_o && !irq_request_o && !device_reset_o |=> sleep_nop_o
      && cpu_clock_enable_o && !watchdog_clear_o && $stable(powerdown_status_o) && $stable(timeout_status_o);
  endproperty
  a_nop: assert property (p_nop) else $error("sleep not a no-op");
  property p_wake;
    !cpu_clock_enable_o && wake_request_o && !device_reset_o
      |=> cpu_clock_enable_o && watchdog_clear_o && timeout_status_o && !powerdown_status_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on request");
  property p_wdt_wake;
    !cpu_clock_enable_o && watchdog_timeout_i && !device_reset_o
      |-> ##[1:2] cpu_clock_enable_o && !timeout_status_o;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("no watchdog wake");
  property p_wake_clr; $rose(cpu_clock_enable_o) && !$past(device_reset_o) |-> watchdog_clear_o; endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("watchdog kept on wake");
  property p_vec; irq_request_o |-> irq_vector_o == 15'h0004; endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_bor;
    brownout_reset_i |-> device_reset_o ##1 powerdown_status_o && timeout_status_o && cpu_clock_enable_o;
  endproperty
  a_bor: assert property (p_bor) else $error("brownout not a reset");
  // main scenarios reached
  c_nop: cover property (sleep_nop_o);
  c_irq: cover property ($rose(irq_request_o));
  c_wake: cover property (!cpu_clock_enable_o ##1 cpu_clock_enable_o);
endmodule

// ### pisw_partner.sv
// partner: core side issuing sleep, ending prefetch and taking interrupts
// assumes the block's outputs share the system clock
`timescale 1ns/1ps
module pisw_partner (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sleep_req_i,
  input wire logic cpu_clock_enable_i,
  input wire logic irq_request_i,
  output logic sleep_exec_o,
  output logic irq_taken_o,
  output logic prefetch_done_o
);
  logic clk_on_reg;
  // sleep instruction executes when the bench asks
  assign sleep_exec_o = sleep_req_i;
  // prefetched instruction retires the cycle after the clock restarts
  always_ff @(posedge clk_i) begin
    clk_on_reg <= cpu_clock_enable_i | ~nrst_i;
    prefetch_done_o <= nrst_i & cpu_clock_enable_i & ~clk_on_reg;
    irq_taken_o <= nrst_i & irq_request_i & ~irq_taken_o;
  end
endmodule

// ### tb_top.sv
// testbench: register, flag and sleep/wake scenarios against a model
// assumes pisw_core, pisw_partner and pisw_core_props are compiled first
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, nrst_i = 0, reg_write_i = 0, reg_read_i = 0, sleep_req = 0;
  logic serial_rx_level_i = 0, serial_tx_level_i = 0, timer0_event_i = 0, ext_event_i = 0;
  logic change_any_i = 0, watchdog_timeout_i = 0, watchdog_sleep_enable_i = 0;
  logic master_clear_input_i = 0, brownout_reset_i = 0, poweron_reset_i = 0;
  logic converter_dedicated_osc_sel_i = 0;
  logic [1:0] timer_a_clock_sel_i = 0;
  logic [3:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0, request_1_event_i = 0, request_2_event_i = 0, reg_rdata_o;
  logic [7:0] rs = 8'h3e;
  logic [14:0] irq_vector_o;
  logic sleep_exec_i, irq_taken_i, prefetch_done_i, sleep_nop_o, cpu_clock_enable_o;
  logic watchdog_clear_o, watchdog_run_o, low_freq_internal_osc_enable_o, timer_a_run_o;
  logic converter_run_o, port_hold_o, regulator_lowpower_o, device_reset_o, irq_request_o;
  logic wake_request_o, timeout_status_o, powerdown_status_o;
  int err_total = 0, checks = 0, cyc = 0;
  int m[8];
  int wm[8] = '{'hfe, 'hff, 'h89, 'hcf, 'h89, 'h03, 0, 0};
  always #4 clk_i = ~clk_i;
  pisw_core i_pisw_core (.*);
  pisw_partner i_pisw_partner (.clk_i, .nrst_i, .sleep_req_i(sleep_req),
    .cpu_clock_enable_i(cpu_clock_enable_o), .irq_request_i(irq_request_o),
    .sleep_exec_o(sleep_exec_i), .irq_taken_o(irq_taken_i), .prefetch_done_o(prefetch_done_i));
  // ------------------------------------------------------------
  // model, bus tasks and checks
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int wk();
    int p1 = m[3] | (serial_rx_level_i << 5) | (serial_tx_level_i << 4);
    return (((m[1] & p1) | (m[2] & m[4])) != 0 && m[0][6]) || ((m[0] >> 3) & m[0] & 7) != 0;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, e1 = 0, e2 = 0);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    request_1_event_i <= e1;
    request_2_event_i <= e2;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
    request_1_event_i <= 8'h00;
    request_2_event_i <= 8'h00;
    m[a] = d & wm[a] | (a == 5); // reserved regulator bit reads one
    m[3] |= e1 & 'hcf;
    m[4] |= e2 & 'h89;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1;
    chk(reg_rdata_o, m[a] | (a == 3 ? {serial_rx_level_i, serial_tx_level_i, 4'h0} : 0));
    chk(wake_request_o, wk());
  endtask
  task automatic slp;
    @(posedge clk_i);
    sleep_req <= 1'b1;
    @(posedge clk_i);
    sleep_req <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish;
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    m = '{0, 0, 0, 0, 0, 1, 3, 0};
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a);
    repeat (4) for (int a = 1; a < 6; a++) begin
      rs = lfsr(rs);
      wr(a, rs);
      rd(a);
    end
    for (int a = 1; a < 6; a++) wr(a, 0);
    rs = lfsr(rs);
    wr(7, 0, rs, rs);
    rd(3);
    rd(4);
    wr(3, 0, 8'h01);
    rd(3);
    serial_rx_level_i <= 1'b1;
    serial_tx_level_i <= 1'b1;
    wr(3, 0);
    rd(3);
    serial_rx_level_i <= 1'b0;
    serial_tx_level_i <= 1'b0;
    wr(4, 0);
    wr(2, 8'h89);
    wr(7, 0, 0, 8'h80);
    rd(2);
    wr(0, 8'h40);
    rd(0);
    slp;
    chk({sleep_nop_o, cpu_clock_enable_o, watchdog_clear_o}, 3'b110);
    rd(6);
    wr(4, 0);
    wr(5, 8'h02);
    watchdog_sleep_enable_i <= 1'b1;
    converter_dedicated_osc_sel_i <= 1'b1;
    slp;
    m[6] = 2;
    chk({cpu_clock_enable_o, watchdog_clear_o, port_hold_o, regulator_lowpower_o}, 4'h7);
    chk({watchdog_run_o, converter_run_o, low_freq_internal_osc_enable_o}, 3'h7);
    for (int s = 0; s < 4; s++) begin
      timer_a_clock_sel_i <= s[1:0];
      @(posedge clk_i);
      #1;
      chk(timer_a_run_o, s != 0);
    end
    wr(7, 0, 0, 8'h01);
    repeat (10) if (cpu_clock_enable_o !== 1'b1) @(posedge clk_i);
    #1;
    chk(cpu_clock_enable_o, 1);
    rd(6);
    wr(4, 0);
    wr(0, 8'he0);
    slp;
    timer0_event_i <= 1'b1;
    @(posedge clk_i);
    timer0_event_i <= 1'b0;
    repeat (20) if (irq_request_o !== 1'b1) @(posedge clk_i);
    #1;
    chk({irq_request_o, cpu_clock_enable_o, irq_vector_o}, {2'b11, 15'h0004});
    m[0] = 'h64;
    repeat (3) @(posedge clk_i);
    rd(0);
    wr(0, 0);
    slp;
    watchdog_timeout_i <= 1'b1;
    @(posedge clk_i);
    watchdog_timeout_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    m[6] = 0;
    rd(6);
    wr(0, 8'h18);
    ext_event_i <= 1'b1;
    change_any_i <= 1'b1;
    @(posedge clk_i);
    ext_event_i <= 1'b0;
    m[0] = 'h1b;
    rd(0);
    change_any_i <= 1'b0;
    wr(0, 0);
    m[0] = 0;
    master_clear_input_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk(device_reset_o, 1);
    master_clear_input_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    m = '{0, 0, 0, 0, 0, 1, 3, 0};
    rd(6);
    rd(5);
    slp;
    brownout_reset_i <= 1'b1;
    @(posedge clk_i);
    brownout_reset_i <= 1'b0;
    m = '{0, 0, 0, 0, 0, 1, 3, 0};
    for (int a = 0; a < 7; a++) rd(a);
    tally_and_finish;
  end
endmodule
bind pisw_core pisw_core_props i_pisw_core_props (.*);
